//--- design/ous_host_port.sv
// host bus front end: intel or motorola strobes to access pulses
`timescale 1ns/1ps
`default_nettype none
module ous_host_port
(
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             intel_sel_i,
    input  wire logic             cs_n_i,
    input  wire logic             rd_n_i,
    input  wire logic             wr_n_i,
    input  wire logic [7:0]       addr_i,
    input  wire logic [7:0]       data_i,
    output ous_pkg::ous_acc_t     acc_o,
    output logic                  rd_busy_o
);

    ous_pkg::ous_port_st_t state_q;
    ous_pkg::ous_port_st_t state_d;
    ous_pkg::ous_acc_t     acc_q;
    wire logic             rd_req;
    wire logic             wr_req;
    wire logic             go_wr;
    wire logic             go_rd;

    // motorola: write strobe pin is read/not-write
    assign rd_req = !cs_n_i && (intel_sel_i ? !rd_n_i : wr_n_i); // [RL18]
    assign wr_req = !cs_n_i && !wr_n_i; // [RL18]
    assign go_wr  = (state_q == ous_pkg::OUS_IDLE) && wr_req;
    assign go_rd  = (state_q == ous_pkg::OUS_IDLE) && !wr_req && rd_req;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ous_pkg::OUS_IDLE:
            begin
                if (go_wr)
                    state_d = ous_pkg::OUS_WRITE;
                else if (go_rd)
                    state_d = ous_pkg::OUS_READ;
            end
            ous_pkg::OUS_READ:
            begin
                if (!rd_req)
                    state_d = ous_pkg::OUS_IDLE;
            end
            ous_pkg::OUS_WRITE:
            begin
                if (!wr_req)
                    state_d = ous_pkg::OUS_IDLE;
            end
            default:
                state_d = ous_pkg::OUS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= ous_pkg::OUS_IDLE;
            acc_q   <= '0;
        end
        else if (ce_i)
        begin
            state_q  <= state_d;
            acc_q.wr <= go_wr;
            acc_q.rd <= go_rd;
            if (go_wr || go_rd)
            begin
                acc_q.addr  <= addr_i;
                acc_q.wdata <= data_i;
            end
        end
    end

    assign acc_o     = acc_q;
    assign rd_busy_o = (state_q == ous_pkg::OUS_READ);

endmodule : ous_host_port
`default_nettype wire

//--- design/ous_map.svh
// register offsets, field positions, reset values and counts
`ifndef OUS_MAP_SVH
`define OUS_MAP_SVH
`define OUS_NUM_CH        8
`define OUS_ADDR_CFG_BIT  7
`define OUS_CH_SEL_HI     6
`define OUS_CH_SEL_LO     4
`define OUS_REG_DIV_LO    4'h0
`define OUS_REG_DIV_HI    4'h1
`define OUS_REG_DIV_FR    4'h2
`define OUS_REG_QUEUE     4'h3
`define OUS_REG_LINE_EXT  4'h4
`define OUS_REG_AUX       4'h5
`define OUS_CFG_SRESET    8'h80
`define OUS_CFG_OCT       8'h81
`define OUS_CFG_BCAST     8'h82
`define OUS_RST_DIV_LO    8'h01
`define OUS_RST_DIV_HI    8'h00
`define OUS_RST_DIV_FR    4'h0
`define OUS_RST_QUEUE     8'h00
`define OUS_RST_LINE_EXT  8'h00
`define OUS_RST_AUX       8'h00
`define OUS_RST_OCT       8'h00
`define OUS_RST_BCAST     1'b0
`define OUS_BCAST_BIT     0
`define OUS_FIFO_EN_BIT   0
`define OUS_RS485_BIT     0
`define OUS_PRESC_BIT     7
`define OUS_PRESC_LAST    2'h3
`define OUS_BIT_LAST_16X  4'hf
`define OUS_BIT_LAST_8X   4'h7
`endif

//--- design/ous_pkg.sv
// shared types of the octal uart select block
package ous_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ous_acc_t;

    typedef struct packed {
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [3:0] div_fr;
        logic [7:0] queue;
        logic [7:0] line_ext;
        logic [7:0] aux;
    } ous_chan_t;

    typedef enum logic [1:0] {
        OUS_IDLE  = 2'b00,
        OUS_READ  = 2'b01,
        OUS_WRITE = 2'b10
    } ous_port_st_t;

endpackage : ous_pkg

//--- design/ous_rate_gen.sv
// per channel prescaler and fractional sampling clock generator
`timescale 1ns/1ps
`default_nettype none
`include "ous_map.svh"
module ous_rate_gen
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        clr_i,
    input  wire logic        presc4_i,
    input  wire logic        oct_i,
    input  wire logic [15:0] div_int_i,
    input  wire logic [3:0]  div_frac_i,
    output logic             sample_o,
    output logic             bit_o
);

    logic [1:0]  pre_q;
    logic [16:0] cnt_q;
    logic [3:0]  acc_q;
    logic        stretch_q;
    logic [3:0]  bit_q;
    wire  logic        pre_tick;
    wire  logic [16:0] period;
    wire  logic [16:0] cnt_inc;
    wire  logic        wrap;
    wire  logic [4:0]  acc_sum;
    wire  logic [3:0]  bit_last;

    assign pre_tick = !presc4_i || (pre_q == `OUS_PRESC_LAST); // [RL10]
    // integer zero behaves as one
    assign period   = {1'b0, (div_int_i == 16'h0000) ? 16'h0001 : div_int_i}
                    + {16'h0000, stretch_q}; // [RL11] [RL15]
    assign cnt_inc  = cnt_q + 17'h0_0001;
    assign wrap     = pre_tick && (cnt_inc >= period);
    assign acc_sum  = {1'b0, acc_q} + {1'b0, div_frac_i}; // [RL14] [RL19]
    assign bit_last = oct_i ? `OUS_BIT_LAST_8X : `OUS_BIT_LAST_16X; // [RL16]

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pre_q     <= '0;
            cnt_q     <= '0;
            acc_q     <= '0;
            stretch_q <= 1'b0;
            bit_q     <= '0;
            sample_o  <= 1'b0;
            bit_o     <= 1'b0;
        end
        else if (ce_i)
        begin
            if (clr_i)
            begin
                pre_q     <= '0;
                cnt_q     <= '0;
                acc_q     <= '0;
                stretch_q <= 1'b0;
                bit_q     <= '0;
                sample_o  <= 1'b0;
                bit_o     <= 1'b0;
            end
            else
            begin
                pre_q    <= pre_tick ? 2'h0 : pre_q + 2'h1; // [RL10]
                sample_o <= wrap; // [RL12]
                bit_o    <= wrap && (bit_q == bit_last); // [RL16]
                if (pre_tick)
                    cnt_q <= wrap ? 17'h0_0000 : cnt_inc;
                if (wrap)
                begin
                    // carry lengthens the next period by one tick
                    acc_q     <= acc_sum[3:0]; // [RL19] [RL17]
                    stretch_q <= acc_sum[4]; // [RL19]
                    bit_q     <= (bit_q >= bit_last) ? 4'h0 : bit_q + 4'h1;
                end
            end
        end
    end

endmodule : ous_rate_gen
`default_nettype wire

//--- design/ous_top.sv
// octal uart channel select, broadcast write, levels and rate generators
//
// Contract
// [RL1] hardware reset clears all eight channels
// [RL2] reset register write clears selected channels
// [RL3] address bits 6:4 pick the channel
// [RL4] broadcast bit writes all eight channels
// [RL5] host clears broadcast before channel reads
// [RL6] tx level high above trigger, fifo mode
// [RL7] rs485 mode: tx low when transmitter empty
// [RL8] rx level high below trigger level
// [RL9] one clock drives every channel generator
// [RL10] line ext bit7 selects prescale one/four
// [RL11] divisor one to just under 65536
// [RL12] generator output is the sampling clock
// [RL13] divisor resets to one
// [RL14] fraction holds four bits, sixteenths
// [RL15] integer divisor split low/high byte
// [RL16] eight times mode: eight clocks per bit
// [RL17] odd fraction in 8x mode jitters
// [RL18] bus style pin picks strobe meaning
// [RL19] fraction by stretching selected periods
`timescale 1ns/1ps
`default_nettype none
`include "ous_map.svh"
module ous_top
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       intel_sel_i,
    input  wire logic       cs_n_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] data_i,
    input  wire logic [7:0] tx_above_trig_i,
    input  wire logic [7:0] tx_all_empty_i,
    input  wire logic [7:0] rx_above_trig_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    output logic      [7:0] tx_int_o,
    output logic      [7:0] rx_int_o,
    output logic      [7:0] sample_tick_o,
    output logic      [7:0] bit_tick_o,
    output logic      [7:0] oct_mode_o,
    output logic      [7:0] chan_reset_o
);

    ////////////////////////////////////////////////////////////////////////
    // host access

    ous_pkg::ous_acc_t acc;
    wire logic         rd_busy;

    ous_host_port u_port
    (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .intel_sel_i (intel_sel_i),
        .cs_n_i      (cs_n_i),
        .rd_n_i      (rd_n_i),
        .wr_n_i      (wr_n_i),
        .addr_i      (addr_i),
        .data_i      (data_i),
        .acc_o       (acc),
        .rd_busy_o   (rd_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire logic       is_cfg;
    wire logic [2:0] ch_sel;
    wire logic [3:0] reg_sel;
    wire logic       cfg_wr;
    wire logic       chan_wr;
    wire logic       wr_sreset;
    wire logic       wr_oct;
    wire logic       wr_bcast;
    wire logic [7:0] ch_we;

    assign is_cfg    = acc.addr[`OUS_ADDR_CFG_BIT];
    assign ch_sel    = acc.addr[`OUS_CH_SEL_HI:`OUS_CH_SEL_LO]; // [RL3]
    assign reg_sel   = acc.addr[3:0];
    assign cfg_wr    = acc.wr && is_cfg;
    assign chan_wr   = acc.wr && !is_cfg;
    assign wr_sreset = cfg_wr && (acc.addr == `OUS_CFG_SRESET); // [RL2]
    assign wr_oct    = cfg_wr && (acc.addr == `OUS_CFG_OCT);
    assign wr_bcast  = cfg_wr && (acc.addr == `OUS_CFG_BCAST);

    ////////////////////////////////////////////////////////////////////////
    // device configuration registers

    logic       bcast_q;
    logic [7:0] oct_q;
    logic [7:0] srst_q;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bcast_q <= `OUS_RST_BCAST;
            oct_q   <= `OUS_RST_OCT;
            srst_q  <= '0;
        end
        else if (ce_i)
        begin
            if (wr_bcast)
                bcast_q <= acc.wdata[`OUS_BCAST_BIT];
            if (wr_oct)
                oct_q <= acc.wdata;
            // one cycle reset pulse per selected channel
            srst_q <= wr_sreset ? acc.wdata : 8'h00; // [RL2]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per channel registers

    ous_pkg::ous_chan_t ch_q [0:7];

    genvar g;
    generate
        for (g = 0; g < `OUS_NUM_CH; g = g + 1)
        begin : g_we
            // broadcast ignores the channel number
            assign ch_we[g] = chan_wr
                && (bcast_q || (ch_sel == 3'(g))); // [RL3] [RL4]
        end
    endgenerate

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < `OUS_NUM_CH; i++)
            begin
                ch_q[i].div_lo   <= `OUS_RST_DIV_LO; // [RL1] [RL13]
                ch_q[i].div_hi   <= `OUS_RST_DIV_HI; // [RL13]
                ch_q[i].div_fr   <= `OUS_RST_DIV_FR; // [RL13]
                ch_q[i].queue    <= `OUS_RST_QUEUE;
                ch_q[i].line_ext <= `OUS_RST_LINE_EXT;
                ch_q[i].aux      <= `OUS_RST_AUX;
            end
        end
        else if (ce_i)
        begin
            for (int i = 0; i < `OUS_NUM_CH; i++)
            begin
                if (srst_q[i])
                begin
                    ch_q[i].div_lo   <= `OUS_RST_DIV_LO; // [RL2] [RL13]
                    ch_q[i].div_hi   <= `OUS_RST_DIV_HI;
                    ch_q[i].div_fr   <= `OUS_RST_DIV_FR;
                    ch_q[i].queue    <= `OUS_RST_QUEUE;
                    ch_q[i].line_ext <= `OUS_RST_LINE_EXT;
                    ch_q[i].aux      <= `OUS_RST_AUX;
                end
                else if (ch_we[i])
                begin
                    if (reg_sel == `OUS_REG_DIV_LO)
                        ch_q[i].div_lo <= acc.wdata; // [RL15]
                    else if (reg_sel == `OUS_REG_DIV_HI)
                        ch_q[i].div_hi <= acc.wdata; // [RL15]
                    else if (reg_sel == `OUS_REG_DIV_FR)
                        ch_q[i].div_fr <= acc.wdata[3:0]; // [RL14]
                    else if (reg_sel == `OUS_REG_QUEUE)
                        ch_q[i].queue <= acc.wdata;
                    else if (reg_sel == `OUS_REG_LINE_EXT)
                        ch_q[i].line_ext <= acc.wdata;
                    else if (reg_sel == `OUS_REG_AUX)
                        ch_q[i].aux <= acc.wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    ous_pkg::ous_chan_t rd_ch;
    wire logic [7:0]    chan_rdata;
    wire logic [7:0]    cfg_rdata;
    wire logic [7:0]    rdata;

    // reads always follow the channel number
    assign rd_ch = ch_q[ch_sel]; // [RL3] [RL5]

    assign chan_rdata =
        (reg_sel == `OUS_REG_DIV_LO)   ? rd_ch.div_lo :
        (reg_sel == `OUS_REG_DIV_HI)   ? rd_ch.div_hi :
        (reg_sel == `OUS_REG_DIV_FR)   ? {4'h0, rd_ch.div_fr} : // [RL14]
        (reg_sel == `OUS_REG_QUEUE)    ? rd_ch.queue :
        (reg_sel == `OUS_REG_LINE_EXT) ? rd_ch.line_ext :
        (reg_sel == `OUS_REG_AUX)      ? rd_ch.aux :
                                         8'h00;

    assign cfg_rdata =
        (acc.addr == `OUS_CFG_OCT)   ? oct_q :
        (acc.addr == `OUS_CFG_BCAST) ? {7'h00, bcast_q} :
                                       8'h00;

    assign rdata = is_cfg ? cfg_rdata : chan_rdata;

    logic [7:0] data_q;
    logic       data_oe_q;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            data_q    <= '0;
            data_oe_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (acc.rd)
                data_q <= rdata;
            data_oe_q <= rd_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt levels

    logic [7:0] tx_int_q;
    logic [7:0] rx_int_q;
    wire  logic [7:0] fifo_en;
    wire  logic [7:0] rs485;
    wire  logic [7:0] tx_lvl;
    wire  logic [7:0] rx_lvl;

    generate
        for (g = 0; g < `OUS_NUM_CH; g = g + 1)
        begin : g_lvl
            assign fifo_en[g] = ch_q[g].queue[`OUS_FIFO_EN_BIT];
            assign rs485[g]   = ch_q[g].aux[`OUS_RS485_BIT];
            // low while below trigger; rs485 also low when empty
            assign tx_lvl[g]  = fifo_en[g] && tx_above_trig_i[g]
                && !(rs485[g] && tx_all_empty_i[g]); // [RL6] [RL7]
            assign rx_lvl[g]  = fifo_en[g] && !rx_above_trig_i[g]; // [RL8]
        end
    endgenerate

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_int_q <= '0;
            rx_int_q <= '0;
        end
        else if (ce_i)
        begin
            tx_int_q <= tx_lvl; // [RL6] [RL7]
            rx_int_q <= rx_lvl; // [RL8]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rate generators

    wire logic [7:0] smp;
    wire logic [7:0] bit_t;

    generate
        for (g = 0; g < `OUS_NUM_CH; g = g + 1)
        begin : g_rate
            // shared reference clock for all channels
            ous_rate_gen u_gen
            (
                .ref_clk_i  (ref_clk_i), // [RL9]
                .rst_i      (rst_i),
                .ce_i       (ce_i),
                .clr_i      (srst_q[g]), // [RL2]
                .presc4_i   (ch_q[g].line_ext[`OUS_PRESC_BIT]), // [RL10]
                .oct_i      (oct_q[g]), // [RL16]
                .div_int_i  ({ch_q[g].div_hi, ch_q[g].div_lo}), // [RL15]
                .div_frac_i (ch_q[g].div_fr), // [RL14]
                .sample_o   (smp[g]), // [RL12]
                .bit_o      (bit_t[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign data_o        = data_q;
    assign data_oe_o     = data_oe_q;
    assign tx_int_o      = tx_int_q;
    assign rx_int_o      = rx_int_q;
    assign sample_tick_o = smp;
    assign bit_tick_o    = bit_t;
    assign oct_mode_o    = oct_q;
    assign chan_reset_o  = srst_q;

endmodule : ous_top
`default_nettype wire

//--- sim/ous_host_model.sv
// host processor bus model for the octal uart block
`timescale 1ns/1ps
`default_nettype none
module ous_host_model
(
    input  wire logic       ref_clk_i,
    input  wire logic       intel_sel_i,
    input  wire logic [7:0] rdata_i,
    output logic            cs_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial
    begin
        cs_n_o  = 1'b1;
        rd_n_o  = 1'b1;
        wr_n_o  = 1'b1;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end

    ////////////////////////////////////////
    // one access: strobe held four edges, one idle edge after
    task automatic acc(input logic wr, input logic [7:0] a, d,
                       output logic [7:0] q);
        @(posedge ref_clk_i);
        cs_n_o  <= 1'b0;
        addr_o  <= a;
        wdata_o <= d;
        wr_n_o  <= ~wr;
        rd_n_o  <= wr | ~intel_sel_i;
        repeat (3) @(posedge ref_clk_i);
        #1;
        q = rdata_i;
        @(posedge ref_clk_i);
        cs_n_o  <= 1'b1;
        rd_n_o  <= 1'b1;
        wr_n_o  <= 1'b1;
        wdata_o <= ~d;
        @(posedge ref_clk_i);
    endtask : acc
endmodule : ous_host_model
`default_nettype wire

//--- sim/ous_top_properties.sv
// concurrent checks on the octal uart select block ports
`timescale 1ns/1ps
`default_nettype none
module ous_top_properties
(
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       ce_i,
    input wire logic       intel_sel_i,
    input wire logic       cs_n_i,
    input wire logic       rd_n_i,
    input wire logic       wr_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] tx_above_trig_i,
    input wire logic [7:0] tx_all_empty_i,
    input wire logic [7:0] rx_above_trig_i,
    input wire logic [7:0] data_o,
    input wire logic       data_oe_o,
    input wire logic [7:0] tx_int_o,
    input wire logic [7:0] rx_int_o,
    input wire logic [7:0] sample_tick_o,
    input wire logic [7:0] bit_tick_o,
    input wire logic [7:0] oct_mode_o,
    input wire logic [7:0] chan_reset_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rd_go;
        $fell(cs_n_i) && wr_n_i && (!intel_sel_i || !rd_n_i);
    endsequence
    sequence s_wr_go;
        $fell(cs_n_i) && !wr_n_i;
    endsequence

    property p_read_answer;
        s_rd_go |-> ##[2:3] data_oe_o;
    endproperty
    property p_write_quiet;
        s_wr_go |-> !data_oe_o [*4];
    endproperty
    property p_oe_hold;
        data_oe_o |-> !$past(cs_n_i, 2);
    endproperty
    property p_tx_level;
        (tx_int_o & ~$past(tx_above_trig_i)) == 8'h00;
    endproperty
    property p_rx_level;
        (rx_int_o & $past(rx_above_trig_i)) == 8'h00;
    endproperty
    property p_bit_on_sample;
        (bit_tick_o & ~sample_tick_o) == 8'h00;
    endproperty
    property p_reset_quiet;
        $fell(rst_i) |-> {data_oe_o, tx_int_o, rx_int_o, sample_tick_o,
                          bit_tick_o, oct_mode_o, chan_reset_o} == '0;
    endproperty
    property p_soft_once;
        chan_reset_o != 8'h00 |=> chan_reset_o == 8'h00;
    endproperty
    property p_soft_cause;
        chan_reset_o != 8'h00 |-> addr_i == 8'h80 && !cs_n_i && !wr_n_i
                                  && (chan_reset_o & ~data_i) == 8'h00;
    endproperty

    a_read_answer: assert property (p_read_answer)
        else $error("read not answered");
    a_write_quiet: assert property (p_write_quiet)
        else $error("bus driven on write");
    a_oe_hold: assert property (p_oe_hold)
        else $error("bus driven without select");
    a_tx_level: assert property (p_tx_level)
        else $error("tx level without fifo above trigger");
    a_rx_level: assert property (p_rx_level)
        else $error("rx level while fifo above trigger");
    a_bit_on_sample: assert property (p_bit_on_sample)
        else $error("bit tick off sampling tick");
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not cleared by reset");
    a_soft_once: assert property (p_soft_once)
        else $error("soft reset pulse too long");
    a_soft_cause: assert property (p_soft_cause)
        else $error("soft reset without register write");
endmodule : ous_top_properties

bind ous_top ous_top_properties i_props
(
    .ref_clk_i, .rst_i, .ce_i, .intel_sel_i, .cs_n_i, .rd_n_i, .wr_n_i,
    .addr_i, .data_i, .tx_above_trig_i, .tx_all_empty_i, .rx_above_trig_i,
    .data_o, .data_oe_o, .tx_int_o, .rx_int_o, .sample_tick_o,
    .bit_tick_o, .oct_mode_o, .chan_reset_o
);
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the octal uart select block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       intel = 1'b1;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] tx_above = 8'h00;
    logic [7:0] tx_empty = 8'h00;
    logic [7:0] rx_above = 8'h00;
    logic [7:0] rdata;
    logic [7:0] tx_int;
    logic [7:0] rx_int;
    logic [7:0] smp;
    logic [7:0] bitt;
    logic [7:0] oct;
    int         fail_count = 0;
    int         samples_checked = 0;
    int         c;

    always #20 clk = ~clk;

    ous_top i_dut
    (
        .ref_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .intel_sel_i(intel),
        .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr),
        .data_i(wdata), .tx_above_trig_i(tx_above),
        .tx_all_empty_i(tx_empty), .rx_above_trig_i(rx_above),
        .data_o(rdata), .data_oe_o(), .tx_int_o(tx_int), .rx_int_o(rx_int),
        .sample_tick_o(smp), .bit_tick_o(bitt), .oct_mode_o(oct),
        .chan_reset_o()
    );

    ous_host_model i_host
    (
        .ref_clk_i(clk), .intel_sel_i(intel), .rdata_i(rdata),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr),
        .wdata_o(wdata)
    );

    ////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        i_host.acc(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input string n, input logic [7:0] a, e);
        logic [7:0] q;
        i_host.acc(1'b0, a, 8'h00, q);
        chk(n, {8'h00, q}, {8'h00, e});
    endtask : rdc

    task automatic lv(input logic [7:0] ta, te, ra, etx, erx);
        @(posedge clk);
        tx_above <= ta;
        tx_empty <= te;
        rx_above <= ra;
        repeat (2) @(posedge clk);
        #1;
        chk("tx_int", {8'h00, tx_int}, {8'h00, etx});
        chk("rx_int", {8'h00, rx_int}, {8'h00, erx});
    endtask : lv

    // cycles (or sample ticks) over n periods of channel 1
    task automatic span(input logic b, input int n, output int r);
        int k;
        r = 0;
        k = -1;
        repeat (5000)
        begin
            @(posedge clk);
            #1;
            if (k > 0 && (!b || smp[1] === 1'b1))
                r++;
            if ((b ? bitt[1] : smp[1]) === 1'b1)
                k++;
            if (k > n)
                break;
        end
    endtask : span

    ////////////////////////////////////////
    task automatic t_regs();
        rdc("div_lo", 8'h30, 8'h01);
        rdc("div_hi", 8'h31, 8'h00);
        rdc("div_fr", 8'h32, 8'h00);
        rdc("unmapped", 8'h0f, 8'h00);
        for (int i = 0; i < 8; i++)
            wr({1'b0, i[2:0], 4'h0}, 8'h10 + 8'(i));
        for (int i = 0; i < 8; i++)
            rdc("ch_sel", {1'b0, i[2:0], 4'h0}, 8'h10 + 8'(i));
        wr(8'h72, 8'hff);
        rdc("fraction", 8'h72, 8'h0f);
        wr(8'h82, 8'h01);
        rdc("bcast_on", 8'h82, 8'h01);
        wr(8'h21, 8'h5a);
        wr(8'h82, 8'h00);
        rdc("bcast_off", 8'h82, 8'h00);
        for (int i = 0; i < 8; i++)
            rdc("bcast", {1'b0, i[2:0], 4'h1}, 8'h5a);
        wr(8'h80, 8'h04);
        rdc("soft_rd", 8'h80, 8'h00);
        rdc("soft_lo", 8'h20, 8'h01);
        rdc("soft_hi", 8'h21, 8'h00);
        rdc("soft_miss", 8'h10, 8'h11);
        @(posedge clk);
        intel <= 1'b0;
        wr(8'h40, 8'h77);
        rdc("moto", 8'h40, 8'h77);
        @(posedge clk);
        intel <= 1'b1;
    endtask : t_regs

    task automatic t_levels();
        lv(8'h01, 8'h01, 8'h00, 8'h00, 8'h00);
        wr(8'h03, 8'h01);
        lv(8'h01, 8'h01, 8'h00, 8'h01, 8'h01);
        lv(8'h01, 8'h01, 8'h01, 8'h01, 8'h00);
        wr(8'h05, 8'h01);
        lv(8'h01, 8'h01, 8'h01, 8'h00, 8'h00);
        lv(8'h01, 8'h00, 8'h01, 8'h01, 8'h00);
        lv(8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
    endtask : t_levels

    task automatic t_rate();
        wr(8'h11, 8'h00);
        wr(8'h10, 8'h03);
        wr(8'h12, 8'h08);
        span(1'b0, 16, c);
        chk("frac_span", 16'(c), 16'h0038);
        wr(8'h11, 8'h01);
        wr(8'h10, 8'h00);
        wr(8'h12, 8'h00);
        span(1'b0, 2, c);
        chk("int_span", 16'(c), 16'h0200);
        wr(8'h11, 8'h00);
        wr(8'h10, 8'h02);
        wr(8'h14, 8'h80);
        rdc("line_ext", 8'h14, 8'h80);
        span(1'b0, 16, c);
        chk("presc_span", 16'(c), 16'h0080);
        span(1'b1, 1, c);
        chk("bit_16x", 16'(c), 16'h0010);
        wr(8'h81, 8'h02);
        chk("oct", {8'h00, oct}, 16'h0002);
        rdc("oct_rd", 8'h81, 8'h02);
        span(1'b1, 1, c);
        chk("bit_8x", 16'(c), 16'h0008);
    endtask : t_rate

    task automatic t_hw();
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("oct_rst", {8'h00, oct}, 16'h0000);
        rdc("hw_lo", 8'h50, 8'h01);
        rdc("hw_fr", 8'h72, 8'h00);
    endtask : t_hw

    ////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_levels();
        t_rate();
        t_hw();
        give_verdict();
    end

    initial
    begin
        #1000000;
        fail_count++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
